// File: hdl/fbws_regs.svh
// Purpose: Timing counts and field positions for the flash host controller
// Assumes: 200 MHz core clock
// Notes:   Counts are whole cycles
`ifndef FBWS_REGS_SVH
`define FBWS_REGS_SVH
`define FBWS_SETUP_CYC   8'h02
`define FBWS_ACCESS_CYC  8'h18
`define FBWS_FLOAT_CYC   8'h04
`define FBWS_ADDR_W      20
`define FBWS_DATA_W      16
`define FBWS_BYTE_SEL    0
`endif

// File: hdl/fbws_pkg.sv
// Purpose: Types for the flash host controller
// Assumes: Nothing
// Notes:   Timing counts live in fbws_regs.svh
package fbws_pkg;
    typedef enum logic [1:0] {
        FBWS_MODE_BYTE,
        FBWS_MODE_WORD,
        FBWS_MODE_PROG
    } fbws_mode_t;
endpackage

// File: hdl/fbws_cycle_timer.sv
// Purpose: Down counter timing the phases of one flash bus cycle
// Assumes: Load and count come from the same clock
// Notes:   done_out is high while the count is zero
`timescale 1ns/1ps
`include "fbws_regs.svh"
module fbws_cycle_timer (
    // Clock and reset
    input  wire logic       core_clk_in,
    input  wire logic       rst_n_in,
    // Control
    input  wire logic       load_in,
    input  wire logic [7:0] value_in,
    // Status
    output logic            done_out
);
    logic [7:0] count_ff;
    logic [7:0] nxt_count;

    assign nxt_count = load_in ? value_in :
                       (count_ff != 8'h00) ? count_ff - 8'h01 : 8'h00;
    assign done_out  = (count_ff == 8'h00);

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_ff <= 8'h00;
        end else begin
            count_ff <= nxt_count;
        end
    end
endmodule // fbws_cycle_timer

// File: hdl/fbws_host.sv
// Purpose: Host side controller driving a parallel flash through its pins
// Assumes: Pins sampled through two flops; high voltage switched externally
// Notes:   Read only in byte and word modes; program level by request
// Function
// - Select pin held low for the whole cycle; device responds only then
// - Byte mode: top data pin carries the byte address bit
// - Word mode: address input zero is the word address LSB
// - Program level on width pin only while erase/program is asked
`timescale 1ns/1ps
`include "fbws_regs.svh"
module fbws_host #(
    parameter int ADDR_W = `FBWS_ADDR_W
) (
    // Clock and reset
    input  wire logic              core_clk_in,
    input  wire logic              rst_n_in,
    // User request
    input  wire logic              req_in,
    input  wire fbws_pkg::fbws_mode_t mode_in,
    input  wire logic [ADDR_W:0]   addr_in,
    output logic                   busy_out,
    output logic                   rdata_valid_out,
    output logic [15:0]            rdata_out,
    output logic                   prog_level_out,
    // Flash pins
    output logic                   sel_n_out,
    output logic                   gate_n_out,
    output logic                   width_sel_out,
    output logic [ADDR_W-1:0]      addr_pins_out,
    output logic                   top_byte_addr_out,
    output logic                   top_byte_addr_oe_out,
    input  wire logic [14:0]       data_pins_in,
    input  wire logic              top_data_in
);
    import fbws_pkg::*;

    typedef enum logic [1:0] {S_IDLE, S_SETUP, S_ACCESS, S_FLOAT} fbws_st_t;

    fbws_st_t          st_ff;
    fbws_st_t          nxt_st;
    fbws_mode_t        mode_ff;
    logic [15:0]       pin_raw;
    wire [15:0]        pin_sync;
    logic              load;
    logic [7:0]        load_val;
    logic              tdone;
    logic              take;
    logic              cycle_end;
    logic              access_end;
    logic              byte_mode;
    logic              read_mode;
    logic              gate_open;
    logic [15:0]       captured;
    logic              sel_n_ff;
    logic              gate_n_ff;
    logic              width_ff;
    logic              prog_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic              top_ff;
    logic              top_oe_ff;
    logic              valid_ff;
    logic              busy_ff;
    logic [15:0]       rdata_ff;

    fbws_cycle_timer u_timer (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .load_in     (load),
        .value_in    (load_val),
        .done_out    (tdone)
    );

    // Request taken and phase ends
    assign take       = (st_ff == S_IDLE) && req_in;
    assign cycle_end  = (nxt_st == S_IDLE);
    assign access_end = (st_ff == S_ACCESS) && tdone;
    assign byte_mode  = (mode_ff == FBWS_MODE_BYTE);
    assign read_mode  = (mode_ff != FBWS_MODE_PROG);
    assign gate_open  = (nxt_st == S_ACCESS) && read_mode;

    // Next state and timer loads
    always_comb begin
        nxt_st   = st_ff;
        load     = 1'b0;
        load_val = 8'h00;
        case (st_ff)
            S_IDLE: begin
                if (req_in) begin
                    nxt_st   = S_SETUP;
                    load     = 1'b1;
                    load_val = `FBWS_SETUP_CYC;
                end
            end
            S_SETUP: begin
                if (tdone) begin
                    nxt_st   = S_ACCESS;
                    load     = 1'b1;
                    load_val = `FBWS_ACCESS_CYC;
                end
            end
            S_ACCESS: begin
                if (tdone) begin
                    nxt_st   = S_FLOAT;
                    load     = 1'b1;
                    load_val = `FBWS_FLOAT_CYC;
                end
            end
            S_FLOAT: begin
                if (tdone) begin
                    nxt_st = S_IDLE;
                end
            end
            default: nxt_st = S_IDLE;
        endcase
    end

    assign pin_raw = {top_data_in, data_pins_in};

    // Flash answers with no relation to our clock: two flops per bit
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_sync
            logic s1_ff;
            logic s2_ff;
            always_ff @(posedge core_clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    s1_ff <= 1'b0;
                    s2_ff <= 1'b0;
                end else begin
                    s1_ff <= pin_raw[gi];
                    s2_ff <= s1_ff;
                end
            end
            assign pin_sync[gi] = s2_ff;
        end
    endgenerate

    // Device already steers the addressed byte onto the low lane
    assign captured = byte_mode ? {8'h00, pin_sync[7:0]} :
                                  pin_sync;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_ff <= S_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Mode frozen for the whole cycle so a late change cannot tear it
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode_ff <= FBWS_MODE_WORD;
        end else if (take) begin
            mode_ff <= mode_in;
        end
    end

    // Select held low from setup through float
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sel_n_ff  <= 1'b1;
            gate_n_ff <= 1'b1;
        end else begin
            sel_n_ff  <= cycle_end;
            gate_n_ff <= !gate_open;
        end
    end

    // Width pin and program level change only between cycles
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            width_ff <= 1'b1;
            prog_ff  <= 1'b0;
        end else if (take) begin
            width_ff <= (mode_in != FBWS_MODE_BYTE);
            prog_ff  <= (mode_in == FBWS_MODE_PROG);
        end else if (cycle_end) begin
            prog_ff  <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            addr_ff <= '0;
            top_ff  <= 1'b0;
        end else if (take) begin
            addr_ff <= addr_in[ADDR_W:1];
            top_ff  <= addr_in[`FBWS_BYTE_SEL];
        end
    end

    // Shared pin driven in byte mode only, released as the cycle ends
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            top_oe_ff <= 1'b0;
        end else if (take) begin
            top_oe_ff <= (mode_in == FBWS_MODE_BYTE);
        end else if (cycle_end) begin
            top_oe_ff <= 1'b0;
        end
    end

    // Valid pulses on the same edge that closes the gate
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_ff  <= 1'b0;
            valid_ff <= 1'b0;
        end else begin
            busy_ff  <= !cycle_end;
            valid_ff <= access_end && read_mode;
        end
    end

    // Last sample before the gate closes, long settled by then
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_ff <= 16'h0000;
        end else if (access_end) begin
            rdata_ff <= captured;
        end
    end

    assign sel_n_out            = sel_n_ff;
    assign gate_n_out           = gate_n_ff;
    assign width_sel_out        = width_ff;
    assign prog_level_out       = prog_ff;
    assign addr_pins_out        = addr_ff;
    assign top_byte_addr_out    = top_ff;
    assign top_byte_addr_oe_out = top_oe_ff;
    assign busy_out             = busy_ff;
    assign rdata_valid_out      = valid_ff;
    assign rdata_out            = rdata_ff;
endmodule // fbws_host

// File: test/fbws_flash_model.sv
// Purpose: Behavioural flash device on the host pins
// Assumes: Content is word address xor a5c3
// Notes:   Released lines toggle each cycle except the upper lanes, held high in byte reads
`timescale 1ns/1ps
module fbws_flash_model (
    input  wire logic        clk_in,
    input  wire logic        sel_n_in,
    input  wire logic        gate_n_in,
    input  wire logic        wid_in,
    input  wire logic        prog_in,
    input  wire logic [19:0] addr_in,
    input  wire logic        tba_in,
    input  wire logic        oe_in,
    output logic      [14:0] data_out,
    output logic             top_out
);
    logic [15:0] w, q;
    logic [15:0] flt_ff = 16'h0;
    logic        drv, lsb;
    assign lsb = !wid_in && oe_in && tba_in;
    assign w = addr_in[15:0] ^ 16'ha5c3;
    assign drv = !sel_n_in && !gate_n_in && !prog_in;
    assign q = wid_in ? w : {8'h00, lsb ? w[15:8] : w[7:0]};
    // Toggling float so a stale sample never looks valid
    always @(posedge clk_in) flt_ff <= drv ? ~q : ~flt_ff;
    assign data_out = {drv && wid_in ? q[14:8] : flt_ff[14:8],
                       drv ? q[7:0] : flt_ff[7:0]};
    assign top_out = oe_in ? tba_in
                   : drv && wid_in ? q[15] : flt_ff[15];
endmodule // fbws_flash_model

// File: test/fbws_host_checker.sv
// Purpose: Pin protocol checks on the flash host
// Assumes: Bound to fbws_host
// Notes:   Read and program cycles
`timescale 1ns/1ps
module fbws_host_checker (
    input wire logic                 core_clk_in,
    input wire logic                 rst_n_in,
    input wire logic                 req_in,
    input wire fbws_pkg::fbws_mode_t mode_in,
    input wire logic                 busy_out,
    input wire logic                 rdata_valid_out,
    input wire logic                 prog_level_out,
    input wire logic                 sel_n_out,
    input wire logic                 gate_n_out,
    input wire logic                 width_sel_out,
    input wire logic                 top_byte_addr_oe_out
);
    import fbws_pkg::*;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_take; !busy_out && req_in; endsequence
    sequence s_rd; s_take ##0 mode_in != FBWS_MODE_PROG; endsequence
    property p_gate; !gate_n_out |-> !sel_n_out; endproperty
    a_gate: assert property (p_gate) else $error("gate without select");
    property p_idle;
        !busy_out |-> sel_n_out && gate_n_out && !top_byte_addr_oe_out;
    endproperty
    a_idle: assert property (p_idle) else $error("pins active idle");
    property p_byte; s_take ##0 mode_in == FBWS_MODE_BYTE
        |=> !width_sel_out && !sel_n_out && top_byte_addr_oe_out; endproperty
    a_byte: assert property (p_byte) else $error("byte setup");
    property p_word; s_take ##0 mode_in == FBWS_MODE_WORD
        |=> width_sel_out && !sel_n_out; endproperty
    a_word: assert property (p_word) else $error("word setup");
    property p_oe; top_byte_addr_oe_out |-> !width_sel_out; endproperty
    a_oe: assert property (p_oe) else $error("top pin driven in word");
    property p_prog; prog_level_out |-> !sel_n_out && gate_n_out; endproperty
    a_prog: assert property (p_prog) else $error("program level misuse");
    property p_prog_on; s_take ##0 mode_in == FBWS_MODE_PROG
        |=> prog_level_out && width_sel_out && !sel_n_out; endproperty
    a_prog_on: assert property (p_prog_on) else $error("program off");
    property p_noprog; s_rd |=> !prog_level_out [*8]; endproperty
    a_noprog: assert property (p_noprog) else $error("program on read");
    property p_ans; s_rd |-> ##[20:60] rdata_valid_out; endproperty
    a_ans: assert property (p_ans) else $error("read not answered");
endmodule // fbws_host_checker
bind fbws_host fbws_host_checker fbws_host_checker_inst (.*);

// File: test/flash_bus_width_and_select_test.sv
// Purpose: Self-checking bench for the flash host controller
// Assumes: Model content is word address xor a5c3
// Notes:   Expected reads go through a queue
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("Error %0t: got %h exp %h", $time, g, e); end end
module flash_bus_width_and_select_test;
    import fbws_pkg::*;
    logic        clk = 0, rst_n = 0, req = 0;
    logic        busy, vld, prog, sel_n, gate_n, wid, tba, oe, top;
    fbws_mode_t  mode = FBWS_MODE_BYTE;
    logic [20:0] addr = 21'h0;
    logic [19:0] pins;
    logic [15:0] rdata, e, q[$];
    logic [14:0] data;
    logic [31:0] rs = 32'h9bf, r;
    int          err_count = 0, n_compared = 0, cyc = 0;
    always #2.5 clk = ~clk;
    fbws_host fbws_host_inst (.core_clk_in(clk), .rst_n_in(rst_n),
        .req_in(req), .mode_in(mode), .addr_in(addr), .busy_out(busy),
        .rdata_valid_out(vld), .rdata_out(rdata), .prog_level_out(prog),
        .sel_n_out(sel_n), .gate_n_out(gate_n), .width_sel_out(wid),
        .addr_pins_out(pins), .top_byte_addr_out(tba),
        .top_byte_addr_oe_out(oe), .data_pins_in(data), .top_data_in(top));
    fbws_flash_model fbws_flash_model_inst (.clk_in(clk), .sel_n_in(sel_n),
        .gate_n_in(gate_n), .wid_in(wid), .prog_in(prog), .addr_in(pins),
        .tba_in(tba), .oe_in(oe), .data_out(data), .top_out(top));
    function automatic logic [31:0] xs();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    task automatic complete_run();
        if (err_count == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic rd(input fbws_mode_t m, input logic [20:0] a);
        logic [15:0] w;
        int n;
        w = a[16:1] ^ 16'ha5c3;
        n = 0;
        do begin @(posedge clk); n++; end while (busy !== 1'b0 && n < 200);
        if (n >= 200) err_count++;
        req <= 1'b1;
        mode <= m;
        addr <= a;
        if (m == FBWS_MODE_WORD) q.push_back(w);
        if (m == FBWS_MODE_BYTE) q.push_back({8'h00, a[0] ? w[15:8] : w[7:0]});
        @(posedge clk);
        req <= 1'b0;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin err_count++; complete_run(); end
    end
    // Valid is a one-cycle register pulse, so sample on every edge
    always @(posedge clk) if (vld === 1'b1) begin
        if (q.size() == 0) `CHK(1'b1, 1'b0)
        else begin
            e = q.pop_front();
            `CHK(rdata, e)
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd(FBWS_MODE_WORD, 21'h1fffff);
        rd(FBWS_MODE_BYTE, 21'h000000);
        rd(FBWS_MODE_BYTE, 21'h000001);
        rd(FBWS_MODE_PROG, 21'h000002);
        repeat (16) begin
            r = xs();
            rd(fbws_mode_t'({1'b0, r[0]}), r[21:1]);
        end
        repeat (60) @(posedge clk);
        `CHK(q.size(), 0)
        complete_run();
    end
endmodule // flash_bus_width_and_select_test
